// ---- common/check_pkg.sv ----
// Constants, register map and carrier types for the I/O check-mode tester.
// Assumes a 10 MHz system clock and a device wired with its check-mode pins.
package check_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] MODE_OFF = 8'h00;
  localparam logic [7:0] PAD_OFF = 8'h04;
  localparam logic [7:0] AC_CMD_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;

  // Bus widths and answer codes
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Number of bidirectional pads watched and driven
  localparam int PAD_W = 8;

  // MODE register fields
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_LEVEL_BIT = 3;
  localparam int MODE_HIZ_BIT = 4;
  localparam logic [4:0] MODE_RESET = 5'h00;

  // PAD register fields
  localparam int PAD_VAL_LSB = 0;
  localparam int PAD_OE_LSB = 8;

  // AC_CMD start bit
  localparam int AC_START_BIT = 0;

  // STATUS register fields
  localparam int ST_AC_BUSY = 0;
  localparam int ST_AC_PASS = 1;
  localparam int ST_AC_DONE = 2;
  localparam int ST_AC_MON = 3;
  localparam int ST_DC_MON = 4;
  localparam int ST_MISMATCH = 5;
  localparam int ST_PAD_LSB = 8;

  // Settling time after any pin change before results are believed
  localparam int SETTLE_NS = 1000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

  // Test mode codes held in MODE[2:0]
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_QUIESCENT = 3'h1,
    MODE_OUT_LEVEL = 3'h2,
    MODE_IN_LEVEL = 3'h3,
    MODE_AC_PATH = 3'h4
  } test_mode_t;

  // AC path sequencer states, one-hot
  typedef enum logic [2:0] {
    AC_IDLE = 3'b001,
    AC_SETTLE = 3'b010,
    AC_CHECK = 3'b100
  } ac_state_t;

  // The four select pins driven into the device
  typedef struct packed {
    logic enable;
    logic direction;
    logic level;
    logic quiet;
  } test_pins_t;

endpackage

// ---- verilog/io_check_mode_controller.sv ----
// Tester-side controller for a device's I/O check-mode pins.
// Assumes device pins are synchronous to clk_in and software on AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module io_check_mode_controller
  import check_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // AXI4-Lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Select pins into the device
  output test_pins_t test_pins_out,
  // Monitor pins from the device
  input wire logic ac_monitor_pin_in,
  input wire logic dc_monitor_pin_in,
  // Bidirectional pads, split into three signals
  input wire logic [PAD_W-1:0] bidir_pad_in,
  output logic [PAD_W-1:0] bidir_pad_out,
  output logic [PAD_W-1:0] bidir_pad_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [4:0] mode_q;
  logic [2*PAD_W-1:0] pad_q;
  test_pins_t pins_q;
  logic ac_level_q;
  ac_state_t ac_state_q;
  logic [CNT_W-1:0] ac_cnt_q;
  logic [CNT_W-1:0] stable_cnt_q;
  logic ac_pass_q;
  logic ac_done_q;
  logic mismatch_q;
  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode into pin levels

  wire [2:0] mode_sel = mode_q[MODE_SEL_LSB +: 3];
  wire is_quiescent = (mode_sel == MODE_QUIESCENT);
  wire is_out_level = (mode_sel == MODE_OUT_LEVEL);
  wire is_in_level = (mode_sel == MODE_IN_LEVEL);
  wire is_ac = (mode_sel == MODE_AC_PATH);
  // Unknown codes fall back to normal so the device stays functional
  wire in_test = is_quiescent | is_out_level | is_in_level | is_ac;
  test_pins_t pins_d;
  assign pins_d.enable = in_test;
  assign pins_d.direction = is_out_level | is_in_level;
  assign pins_d.level = is_ac ? ac_level_q : (in_test & mode_q[MODE_LEVEL_BIT]);
  // Input-level mode needs pads as inputs, so quiet goes high there too
  assign pins_d.quiet = is_ac | is_in_level | (is_out_level & mode_q[MODE_HIZ_BIT]);
  wire pins_change = (pins_d != pins_q);

  // Pads may be driven only when the device has let go of them
  wire pads_free = ~pins_q.enable | (pins_q.direction & pins_q.quiet);
  // Same test on the next pin levels, so pad enables never lag the pins
  wire pads_free_d = ~pins_d.enable | (pins_d.direction & pins_d.quiet);
  wire settled = (stable_cnt_q == '0);

  // Expected device outputs once settled
  wire expect_out = pins_q.quiet | pins_q.level;
  // Input-level mode shows input results on the DC monitor, not checked here
  wire check_dc = pins_q.enable & settled & ~is_in_level;
  wire check_pads = pins_q.enable & settled & ~pads_free;
  wire dc_bad = check_dc & (dc_monitor_pin_in != expect_out);
  wire pad_bad = check_pads & (bidir_pad_in != {PAD_W{expect_out}});
  wire mismatch_set = dc_bad | pad_bad;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_full_q & w_full_q & ~bvalid_q;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire [DATA_W-1:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire wr_mode = do_write & (awaddr_q == MODE_OFF);
  wire wr_pad = do_write & (awaddr_q == PAD_OFF);
  wire wr_ac = do_write & (awaddr_q == AC_CMD_OFF);
  wire wr_status = do_write & (awaddr_q == STATUS_OFF);
  wire wr_known = wr_mode | wr_pad | wr_ac | wr_status;
  wire [DATA_W-1:0] wr_bits = wdata_q & wmask;
  wire [4:0] mode_next = (mode_q & ~wmask[4:0]) | wr_bits[4:0];
  wire [2*PAD_W-1:0] pad_next = (pad_q & ~wmask[2*PAD_W-1:0]) | wr_bits[2*PAD_W-1:0];
  wire clr_done = wr_status & wr_bits[ST_AC_DONE];
  wire clr_mismatch = wr_status & wr_bits[ST_MISMATCH];

  // AC sequencer start: only in AC path mode and only when idle
  wire ac_start = wr_ac & wr_bits[AC_START_BIT] & is_ac & (ac_state_q == AC_IDLE);
  wire ac_finish = (ac_state_q == AC_CHECK);

  // Read data mux
  wire [DATA_W-1:0] status_word = {
    {(DATA_W-ST_PAD_LSB-PAD_W){1'b0}}, bidir_pad_in, 2'h0, mismatch_q,
    dc_monitor_pin_in, ac_monitor_pin_in, ac_done_q, ac_pass_q, (ac_state_q != AC_IDLE)};
  wire rd_mode = (s_axi_araddr == MODE_OFF);
  wire rd_pad = (s_axi_araddr == PAD_OFF);
  wire rd_ac = (s_axi_araddr == AC_CMD_OFF);
  wire rd_status = (s_axi_araddr == STATUS_OFF);
  wire rd_known = rd_mode | rd_pad | rd_ac | rd_status;
  wire [DATA_W-1:0] rd_word = rd_mode ? {27'h0, mode_q} :
                              rd_pad ? {16'h0, pad_q} :
                              rd_status ? status_word : 32'h0;

  assign s_axi_awready = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready = ~w_full_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel holding registers and response

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full_q <= 1'b0;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_full_q <= 1'b0;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel, answer held until taken
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers, pins and pads

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_q <= MODE_RESET;
      pad_q <= '0;
      pins_q <= '0;
      bidir_pad_out <= '0;
      bidir_pad_oe_out <= '0;
    end else begin
      if (wr_mode) mode_q <= mode_next;
      if (wr_pad) pad_q <= pad_next;
      pins_q <= pins_d;
      // Every pad has a defined value, driven or released
      bidir_pad_out <= pad_q[PAD_VAL_LSB +: PAD_W];
      bidir_pad_oe_out <= pad_q[PAD_OE_LSB +: PAD_W] & {PAD_W{pads_free_d}};
    end
  end

  // Settling counter restarts on every pin change
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stable_cnt_q <= CNT_W'(SETTLE_CYCLES);
    end else if (pins_change) begin
      stable_cnt_q <= CNT_W'(SETTLE_CYCLES);
    end else if (!settled) begin
      stable_cnt_q <= stable_cnt_q - 1'b1;
    end
  end

  // Sticky mismatch flag; a new mismatch beats a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mismatch_q <= 1'b0;
    end else if (mismatch_set) begin
      mismatch_q <= 1'b1;
    end else if (clr_mismatch) begin
      mismatch_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AC path sequencer: toggle level, wait, compare monitor

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ac_state_q <= AC_IDLE;
      ac_level_q <= 1'b0;
      ac_cnt_q <= '0;
      ac_pass_q <= 1'b0;
    end else begin
      unique case (ac_state_q)
        AC_IDLE: begin
          if (ac_start) begin
            ac_level_q <= ~ac_level_q;
            ac_cnt_q <= CNT_W'(SETTLE_CYCLES);
            ac_state_q <= AC_SETTLE;
          end
        end
        AC_SETTLE: begin
          // Delay path must settle before the monitor is believed
          if (ac_cnt_q == '0) ac_state_q <= AC_CHECK;
          else ac_cnt_q <= ac_cnt_q - 1'b1;
        end
        AC_CHECK: begin
          ac_pass_q <= (ac_monitor_pin_in == ac_level_q);
          ac_state_q <= AC_IDLE;
        end
        default: ac_state_q <= AC_IDLE;
      endcase
    end
  end

  // Done flag: completion beats a software clear
  always_ff @(posedge clk_in) begin
    if (rst_in) ac_done_q <= 1'b0;
    else if (ac_finish) ac_done_q <= 1'b1;
    else if (clr_done) ac_done_q <= 1'b0;
  end

  assign test_pins_out = pins_q;

endmodule
`default_nettype wire

// ---- dv/check_ctrl_properties.sv ----
// Port checker for the check-mode tester controller.
// Bound into the controller top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module check_ctrl_properties
  import check_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Device side
  input wire test_pins_t test_pins_out,
  input wire logic [PAD_W-1:0] bidir_pad_oe_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // Accepted requests
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_reset_idle;
    disable iff (1'h0) rst_in |=> !s_axi_bvalid && !s_axi_rvalid && test_pins_out == '0;
  endproperty
  property p_normal_zero;
    !test_pins_out.enable |-> test_pins_out == '0;
  endproperty
  // Pads must be released while the device may drive them
  property p_pads_free;
    test_pins_out.enable && !(test_pins_out.direction && test_pins_out.quiet)
      |-> bidir_pad_oe_out == '0;
  endproperty
  property p_pins_cause;
    $changed(test_pins_out) |-> $past(s_axi_bvalid);
  endproperty
  property p_wr_answer;
    s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  property p_wr_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_rd_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("not idle after reset");
  a_normal_zero: assert property (p_normal_zero)
    else $error("select pins active in normal mode");
  a_pads_free: assert property (p_pads_free)
    else $error("pad driven against the device");
  a_pins_cause: assert property (p_pins_cause)
    else $error("pins changed without a write");
  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer late or early");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer missing");
  a_wr_busy: assert property (p_wr_busy)
    else $error("write taken while answering");
  a_rd_busy: assert property (p_rd_busy)
    else $error("read taken while answering");
endmodule
bind io_check_mode_controller check_ctrl_properties i_check_ctrl_properties (
  .clk_in(clk_in), .rst_in(rst_in), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .test_pins_out(test_pins_out),
  .bidir_pad_oe_out(bidir_pad_oe_out)
);
`default_nettype wire

// ---- dv/check_device_model.sv ----
// Behavioural device with the check-mode pad steering.
// Pad wire resolved here from both parties' enables.
`timescale 1ns/1ps
`default_nettype none
module check_device_model
  import check_pkg::*;
#(
  parameter int AC_DELAY_NS = 250
)
(
  // Controls
  input wire logic clk_in,
  input wire test_pins_t pins_in,
  input wire logic fault_in,
  input wire logic [PAD_W-1:0] ctl_pad_in,
  input wire logic [PAD_W-1:0] ctl_oe_in,
  // Pins back to the tester
  output logic ac_monitor_pin_out,
  output logic dc_monitor_pin_out,
  output logic [PAD_W-1:0] pad_wire_out
);
  logic [PAD_W-1:0] float_q = '0;
  // Steering: override, direction, forced value
  wire override_w = pins_in.enable;
  wire drive_w = override_w && !(pins_in.direction && pins_in.quiet);
  wire forced_w = pins_in.quiet | pins_in.level;
  // Delay cell path; fault inverts it only when a test asks
  assign #(AC_DELAY_NS) ac_monitor_pin_out = override_w ? pins_in.level ^ fault_in : float_q[0];
  assign dc_monitor_pin_out = override_w ? forced_w ^ fault_in : float_q[1];
  // Undriven: pull-up in normal mode, off in test mode
  assign pad_wire_out = drive_w ? {PAD_W{forced_w}} :
    (ctl_oe_in & ctl_pad_in) | (~ctl_oe_in & (override_w ? float_q : '1));
  // Floating pattern changes every cycle
  always_ff @(posedge clk_in) begin
    float_q <= ~float_q;
  end
endmodule
`default_nettype wire

// ---- dv/test_io_check_mode_controller.sv ----
// Self-checking bench of the check-mode tester controller.
// Drives AXI4-Lite by hand; a device model sits on the pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin n_errors++; $display("MISMATCH %0t %s", $time, m); end end
module test_io_check_mode_controller
  import check_pkg::*;
;
  logic clk_in = 1'h0, rst_in = 1'h1, fault = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  wire logic awready, wready, bvalid, arready, rvalid, ac_mon, dc_mon;
  wire logic [1:0] bresp, rresp;
  wire logic [DATA_W-1:0] rdata;
  wire test_pins_t pins;
  wire logic [PAD_W-1:0] pad_o, pad_oe, pad_w;
  int n_errors = 0, checks_done = 0;
  always #50 clk_in = ~clk_in;
  io_check_mode_controller i_io_check_mode_controller (.clk_in(clk_in), .rst_in(rst_in),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .test_pins_out(pins), .ac_monitor_pin_in(ac_mon), .dc_monitor_pin_in(dc_mon),
    .bidir_pad_in(pad_w), .bidir_pad_out(pad_o), .bidir_pad_oe_out(pad_oe));
  check_device_model i_check_device_model (.clk_in(clk_in), .pins_in(pins), .fault_in(fault),
    .ctl_pad_in(pad_o), .ctl_oe_in(pad_oe), .ac_monitor_pin_out(ac_mon),
    .dc_monitor_pin_out(dc_mon), .pad_wire_out(pad_w));
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One bus transfer; ready sampled at the falling edge before the taking edge
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er, output logic [31:0] q);
    logic ta, tw, tr, fin;
    logic [1:0] r;
    int n;
    @(posedge clk_in);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_in);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = arvalid && arready;
      fin = w ? bvalid : rvalid;
      r = w ? bresp : rresp;
      q = rdata;
      @(posedge clk_in);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tr) arvalid <= 1'h0;
      if (fin) begin
        bready <= 1'h0;
        rready <= 1'h0;
        break;
      end
    end
    if (n == 40) begin
      n_errors++;
      results;
    end
    `CHK(r, er, "bus response")
  endtask
  function automatic test_pins_t exp_pins(input int m, input logic l, input logic h);
    case (m)
      1: exp_pins = '{1'h1, 1'h0, l, 1'h0};
      2: exp_pins = '{1'h1, 1'h1, l, h};
      3: exp_pins = '{1'h1, 1'h1, l, 1'h1};
      4: exp_pins = '{1'h1, 1'h0, 1'h0, 1'h1};
      default: exp_pins = '0;
    endcase
  endfunction
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_modes;
    logic [31:0] q;
    test_pins_t e;
    logic fv;
    xfer(1, MODE_OFF, 32'h0, RESP_OKAY, q);
    @(negedge clk_in);
    `CHK(pins, test_pins_t'('0), "reset pins")
    xfer(1, PAD_OFF, 32'h0000_FFA5, RESP_OKAY, q);
    for (int i = 0; i < 10; i++) begin
      e = exp_pins(i % 5, 1'(i / 5), 1'(i / 5));
      xfer(1, MODE_OFF, {27'h0, 1'(i / 5), 1'(i / 5), 3'(i % 5)}, RESP_OKAY, q);
      repeat (SETTLE_CYCLES + 2) @(posedge clk_in);
      `CHK(pins, e, "select pins")
      xfer(0, STATUS_OFF, 32'h0, RESP_OKAY, q);
      fv = e.quiet | e.level;
      `CHK(q[15:8], (e.enable && !(e.direction && e.quiet)) ? {8{fv}} : 8'hA5, "pads")
      `CHK(q[ST_MISMATCH], 1'h0, "false mismatch")
      if (e.enable) `CHK(q[ST_DC_MON], fv, "dc monitor")
    end
    $display("modes done");
  endtask
  // Start the AC path, optionally with a broken device path
  task automatic t_ac(input logic f, input logic lvl);
    logic [31:0] q;
    int n;
    @(posedge clk_in);
    fault <= f;
    xfer(1, AC_CMD_OFF, 32'h1, RESP_OKAY, q);
    // A write hands back stale read data; poll only on fresh status
    q[ST_AC_DONE] = 1'h0;
    for (n = 0; n < 40 && q[ST_AC_DONE] !== 1'h1; n++) xfer(0, STATUS_OFF, 32'h0, RESP_OKAY, q);
    if (n == 40) begin
      n_errors++;
      results;
    end
    `CHK(q[ST_AC_PASS], !f, "ac pass")
    `CHK(pins.level, lvl, "ac level")
    xfer(0, STATUS_OFF, 32'h0, RESP_OKAY, q);
    `CHK(q[ST_AC_MON], lvl ^ f, "ac monitor")
    `CHK(q[ST_MISMATCH], f, "mismatch flag")
    @(posedge clk_in);
    fault <= 1'h0;
    repeat (4) @(posedge clk_in);
    xfer(1, STATUS_OFF, 32'h24, RESP_OKAY, q);
    xfer(0, STATUS_OFF, 32'h0, RESP_OKAY, q);
    `CHK(q[ST_MISMATCH] | q[ST_AC_DONE], 1'h0, "flags cleared")
    $display("ac done");
  endtask
  task automatic t_bad;
    logic [31:0] q;
    xfer(1, 8'h10, 32'h1, RESP_SLVERR, q);
    xfer(0, 8'h10, 32'h0, RESP_SLVERR, q);
    `CHK(q, 32'h0, "unmapped data")
    xfer(0, AC_CMD_OFF, 32'h0, RESP_OKAY, q);
    `CHK(q, 32'h0, "command readback")
    // Unused mode code must leave the device in normal mode
    xfer(1, MODE_OFF, 32'h5, RESP_OKAY, q);
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    `CHK(pins, test_pins_t'('0), "unknown mode")
    $display("bus errors done");
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'h0;
    t_modes;
    t_ac(1'h0, 1'h1);
    t_ac(1'h1, 1'h0);
    t_bad;
    results;
  end
endmodule
`default_nettype wire
